/* File: hw/rip_pkg.sv */
// Purpose: Shared constants and types for the reset, interrupt and pin control block
// Assumes: 20 MHz system clock, APB register access with 32-bit data
// Notes:   Register byte offsets, field positions, reset values and timing counts

package rip_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_CTRL2 = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_MASK  = 8'h0C;
  localparam logic [7:0] A_CFG   = 8'h10;
  localparam logic [7:0] A_FUNC  = 8'h14;
  localparam logic [7:0] A_DIR   = 8'h18;
  localparam logic [7:0] A_DOUT  = 8'h1C;
  localparam logic [7:0] A_DIN   = 8'h20;
  localparam logic [7:0] A_PC    = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CLKSEL_BIT = 14;
  localparam int unsigned BOOT_BIT   = 3;
  localparam int unsigned FLAG_BIT   = 0;

  // Event bits in status and mask
  localparam int unsigned EV_FA = 0;
  localparam int unsigned EV_FB = 1;
  localparam int unsigned EV_U1 = 2;
  localparam int unsigned EV_U2 = 3;
  localparam int unsigned N_EV  = 4;

  // Synchronised pin inputs
  localparam int unsigned S_RST  = 0;
  localparam int unsigned S_FA   = 1;
  localparam int unsigned S_FB   = 2;
  localparam int unsigned S_P0   = 3;
  localparam int unsigned S_BOOT = 6;
  localparam int unsigned S_EMU  = 7;
  localparam int unsigned N_SYNC = 8;

  // Multiplexed pins
  localparam int unsigned N_GPIO = 3;
  localparam int unsigned GP_U1  = 0;
  localparam int unsigned GP_U2  = 1;
  localparam int unsigned GP_CLK = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  SYNC_RST = 8'hFF;
  localparam logic [2:0]  FUNC_RST = 3'h7;
  localparam logic [2:0]  ZERO3    = 3'h0;
  localparam logic [3:0]  ZERO4    = 4'h0;
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [15:0] PC_INC   = 16'h0001;
  localparam logic [31:0] ZERO32   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_NS       = 50;
  localparam int unsigned WD_PULSE_NS  = 500;
  localparam int unsigned WD_PULSE_CYC = (WD_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  WD_CNT_LOAD  = 8'(WD_PULSE_CYC);
  localparam logic [7:0]  CNT_ZERO     = 8'h00;
  localparam logic [7:0]  CNT_ONE      = 8'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic conv_en;
    logic pol2;
    logic pol1;
  } rip_cfg_t;

  typedef enum logic {RIP_HALT, RIP_FETCH} rip_cpu_t;

endpackage : rip_pkg

/* File: hw/rip_pin_ctrl.sv */
// Purpose: Reset, drive-fault, external interrupt and pin control
// Assumes: One clock; APB slave with zero wait states
// Notes:   Pin inputs pass a three-flop synchroniser

`timescale 1ns/1ps
`default_nettype none

module rip_pin_ctrl (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Reset pin (open drain) and watchdog
  input  wire logic        reset_in_n_i,
  output logic             reset_in_n_o,
  output logic             reset_in_n_oe_o,
  input  wire logic        wd_overflow_i,
  // Core control
  output logic             cpu_halt_o,
  output logic      [15:0] program_counter_o,
  // Drive faults
  input  wire logic        drive_fault_in_a_i,
  input  wire logic        drive_fault_in_b_i,
  output logic             pwm_a_hiz_o,
  output logic             pwm_b_hiz_o,
  // Multiplexed pins: 0 user_irq_1, 1 user_irq_2, 2 clock_out_pin
  input  wire logic [2:0]  mux_pin_i,
  output logic      [2:0]  mux_pin_o,
  output logic      [2:0]  mux_pin_oe_o,
  input  wire logic        watchdog_clock_i,
  output logic             conv_start_in_o,
  // Boot enable / external flag pin
  input  wire logic        boot_pin_i,
  output logic             external_flag_out_o,
  output logic             external_flag_oe_o,
  // Crystal output
  input  wire logic        osc_drive_i,
  input  wire logic        emu_output_disable_n_i,
  output logic             crystal_out_o,
  output logic             crystal_out_oe_o,
  // Interrupt
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  s1_q, s2_q, s3_q, flt_q;
  logic [7:0]  chg, rise, fall;
  logic [7:0]  wd_cnt_q;
  logic        wd_busy;
  logic        dev_rst;
  rip_pkg::rip_cpu_t cpu_q;
  logic [15:0] pc_q;
  logic        clksel_q;
  logic        boot_q;
  logic        flag_q;
  logic [3:0]  stat_q, mask_q, ev;
  rip_pkg::rip_cfg_t cfg_q;
  logic [2:0]  func_q, dir_q, dout_q;
  logic        conv_q;
  logic        u1_edge, u2_edge;
  logic        wr, rd_setup, mapped;
  logic [31:0] rdata;
  logic        clk_src;

  // ----------------------------------------------------------------
  // Pin synchroniser and glitch filter
  // ----------------------------------------------------------------
  // Filtered level moves only once stages two and three agree
  // Stages run through reset so the boot strap level is seen while it is held
  always_ff @(posedge sys_clk_i) begin
    s1_q <= {emu_output_disable_n_i, boot_pin_i, mux_pin_i,
             drive_fault_in_b_i, drive_fault_in_a_i, reset_in_n_i};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  genvar gi;
  generate
    for (gi = 0; gi < rip_pkg::N_SYNC; gi++) begin : g_flt
      assign chg[gi]  = (s2_q[gi] == s3_q[gi]) && (s3_q[gi] != flt_q[gi]);
      assign rise[gi] = chg[gi] && s3_q[gi];
      assign fall[gi] = chg[gi] && !s3_q[gi];
      always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
          flt_q[gi] <= rip_pkg::SYNC_RST[gi];
        end else if (chg[gi]) begin
          flt_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Watchdog reset pulse
  // ----------------------------------------------------------------
  // Counter is cleared only by the system reset, not by the pulse it makes
  assign wd_busy = (wd_cnt_q != rip_pkg::CNT_ZERO);

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      wd_cnt_q <= rip_pkg::CNT_ZERO;
    end else if (wd_overflow_i && !wd_busy) begin
      wd_cnt_q <= rip_pkg::WD_CNT_LOAD;
    end else if (wd_busy) begin
      wd_cnt_q <= wd_cnt_q - rip_pkg::CNT_ONE;
    end
  end

  // Open drain: drive low only while the pulse runs
  assign reset_in_n_o    = 1'b0;
  assign reset_in_n_oe_o = wd_busy;

  // Internal reset: system reset, pin low, or watchdog pulse
  assign dev_rst = !resetn_i || !flt_q[rip_pkg::S_RST] || wd_busy;

  // ----------------------------------------------------------------
  // Core fetch control
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      cpu_q <= rip_pkg::RIP_HALT;
      pc_q  <= rip_pkg::PC_RST;
    end else begin
      case (cpu_q)
        rip_pkg::RIP_HALT: begin
          cpu_q <= rip_pkg::RIP_FETCH;
          pc_q  <= rip_pkg::PC_RST;
        end
        rip_pkg::RIP_FETCH: begin
          pc_q <= pc_q + rip_pkg::PC_INC;
        end
        default: begin
          cpu_q <= rip_pkg::RIP_HALT;
          pc_q  <= rip_pkg::PC_RST;
        end
      endcase
    end
  end

  assign cpu_halt_o        = dev_rst || (cpu_q == rip_pkg::RIP_HALT);
  assign program_counter_o = pc_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      rip_pkg::A_CTRL, rip_pkg::A_CTRL2, rip_pkg::A_STAT,
      rip_pkg::A_MASK, rip_pkg::A_CFG, rip_pkg::A_FUNC,
      rip_pkg::A_DIR, rip_pkg::A_DOUT, rip_pkg::A_DIN,
      rip_pkg::A_PC: is_mapped = 1'b1;
      default:       is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign mapped    = is_mapped(paddr_i);
  assign wr        = psel_i && penable_i && pwrite_i;
  assign rd_setup  = psel_i && !penable_i && !pwrite_i;
  assign pready_o  = psel_i && penable_i;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // Read data is captured in the setup cycle so it comes from a flop
  always_comb begin
    rdata = rip_pkg::ZERO32;
    case (paddr_i)
      rip_pkg::A_CTRL:  rdata[rip_pkg::CLKSEL_BIT] = clksel_q;
      rip_pkg::A_CTRL2: begin
        rdata[rip_pkg::BOOT_BIT] = boot_q;
        rdata[rip_pkg::FLAG_BIT] = flag_q;
      end
      rip_pkg::A_STAT:  rdata[3:0] = stat_q;
      rip_pkg::A_MASK:  rdata[3:0] = mask_q;
      rip_pkg::A_CFG:   rdata[2:0] = cfg_q;
      rip_pkg::A_FUNC:  rdata[2:0] = func_q;
      rip_pkg::A_DIR:   rdata[2:0] = dir_q;
      rip_pkg::A_DOUT:  rdata[2:0] = dout_q;
      rip_pkg::A_DIN:   rdata[2:0] = flt_q[rip_pkg::S_P0 +: rip_pkg::N_GPIO];
      rip_pkg::A_PC:    rdata[15:0] = pc_q;
      default:          rdata = rip_pkg::ZERO32;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      prdata_o <= rip_pkg::ZERO32;
    end else if (rd_setup) begin
      prdata_o <= rdata;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      clksel_q <= 1'b0;
      cfg_q    <= rip_pkg::ZERO3;
      mask_q   <= rip_pkg::ZERO4;
      func_q   <= rip_pkg::FUNC_RST;
      dir_q    <= rip_pkg::ZERO3;
      dout_q   <= rip_pkg::ZERO3;
    end else if (wr) begin
      case (paddr_i)
        rip_pkg::A_CTRL: clksel_q <= pwdata_i[rip_pkg::CLKSEL_BIT];
        rip_pkg::A_MASK: mask_q   <= pwdata_i[3:0];
        rip_pkg::A_CFG:  cfg_q    <= pwdata_i[2:0];
        rip_pkg::A_FUNC: func_q   <= pwdata_i[2:0];
        rip_pkg::A_DIR:  dir_q    <= pwdata_i[2:0];
        rip_pkg::A_DOUT: dout_q   <= pwdata_i[2:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Boot enable sample and external flag
  // ----------------------------------------------------------------
  // Pin is an input while in reset; the agreed level is taken each cycle
  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      flag_q <= 1'b1;
      if (s2_q[rip_pkg::S_BOOT] == s3_q[rip_pkg::S_BOOT]) begin
        boot_q <= s3_q[rip_pkg::S_BOOT];
      end
    end else if (wr && paddr_i == rip_pkg::A_CTRL2) begin
      flag_q <= pwdata_i[rip_pkg::FLAG_BIT];
    end
  end

  assign external_flag_out_o = flag_q;
  assign external_flag_oe_o  = !dev_rst;

  // ----------------------------------------------------------------
  // Events and sticky status
  // ----------------------------------------------------------------
  assign u1_edge = func_q[rip_pkg::GP_U1] &&
                   (cfg_q.pol1 ? rise[rip_pkg::S_P0 + rip_pkg::GP_U1]
                               : fall[rip_pkg::S_P0 + rip_pkg::GP_U1]);
  assign u2_edge = func_q[rip_pkg::GP_U2] &&
                   (cfg_q.pol2 ? rise[rip_pkg::S_P0 + rip_pkg::GP_U2]
                               : fall[rip_pkg::S_P0 + rip_pkg::GP_U2]);

  assign ev[rip_pkg::EV_FA] = fall[rip_pkg::S_FA];
  assign ev[rip_pkg::EV_FB] = fall[rip_pkg::S_FB];
  assign ev[rip_pkg::EV_U1] = u1_edge;
  assign ev[rip_pkg::EV_U2] = u2_edge;

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      stat_q <= rip_pkg::ZERO4;
    end else begin
      stat_q <= ev | (stat_q & ~((wr && paddr_i == rip_pkg::A_STAT)
                                 ? pwdata_i[3:0] : rip_pkg::ZERO4));
    end
  end

  assign irq_o       = |(stat_q & mask_q);
  assign pwm_a_hiz_o = stat_q[rip_pkg::EV_FA];
  assign pwm_b_hiz_o = stat_q[rip_pkg::EV_FB];

  // Conversion start pulse, one cycle per qualifying edge
  always_ff @(posedge sys_clk_i) begin
    if (dev_rst) begin
      conv_q <= 1'b0;
    end else begin
      conv_q <= u2_edge && cfg_q.conv_en;
    end
  end

  assign conv_start_in_o = conv_q;

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Clock mux is combinational; a switch may glitch the pin once
  assign clk_src = clksel_q ? watchdog_clock_i : sys_clk_i;

  generate
    for (gi = 0; gi < rip_pkg::N_GPIO; gi++) begin : g_pin
      if (gi == rip_pkg::GP_CLK) begin : g_clk
        assign mux_pin_o[gi]    = func_q[gi] ? clk_src : dout_q[gi];
        assign mux_pin_oe_o[gi] = func_q[gi] || dir_q[gi];
      end else begin : g_irq
        assign mux_pin_o[gi]    = dout_q[gi];
        assign mux_pin_oe_o[gi] = !func_q[gi] && dir_q[gi];
      end
    end
  endgenerate

  assign crystal_out_o    = osc_drive_i;
  assign crystal_out_oe_o = flt_q[rip_pkg::S_EMU];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence fault_a_fall;
    fall[rip_pkg::S_FA] && !dev_rst;
  endsequence

  sequence fault_b_fall;
    fall[rip_pkg::S_FB] && !dev_rst;
  endsequence

  chk_pc_held_zero: assert property (
    dev_rst |=> program_counter_o == rip_pkg::PC_RST && cpu_halt_o)
    else $error("program counter not zero in reset");

  chk_fetch_from_zero: assert property (
    (dev_rst ##1 !dev_rst) |-> program_counter_o == rip_pkg::PC_RST
    ##1 (!dev_rst)[*2] |-> program_counter_o == rip_pkg::PC_INC)
    else $error("fetch did not start at zero");

  chk_reset_clears: assert property (
    dev_rst |=> stat_q == rip_pkg::ZERO4 && mask_q == rip_pkg::ZERO4 && !clksel_q)
    else $error("reset left a register set");

  chk_wd_pulse_out: assert property (
    (wd_overflow_i && !wd_busy) |=> (reset_in_n_oe_o && cpu_halt_o)[*8])
    else $error("watchdog pulse not driven on reset pin");

  chk_fault_a_float: assert property (
    fault_a_fall |=> pwm_a_hiz_o ##0 stat_q[rip_pkg::EV_FA])
    else $error("fault A did not float PWM group A");

  chk_fault_b_float: assert property (
    fault_b_fall |=> pwm_b_hiz_o ##0 stat_q[rip_pkg::EV_FB])
    else $error("fault B did not float PWM group B");

  chk_irq_edge_only: assert property (
    u1_edge |=> !u1_edge)
    else $error("user interrupt retriggered on a level");

  chk_irq_polarity: assert property (
    u2_edge |-> s3_q[rip_pkg::S_P0 + rip_pkg::GP_U2] == cfg_q.pol2)
    else $error("user interrupt took the wrong edge");

  chk_conv_start: assert property (
    (u2_edge && cfg_q.conv_en && !dev_rst) |=> conv_start_in_o ##1 !conv_start_in_o)
    else $error("conversion start pulse missing");

  chk_boot_sample: assert property (
    (dev_rst && s2_q[rip_pkg::S_BOOT] == s3_q[rip_pkg::S_BOOT])
    |=> boot_q == $past(s3_q[rip_pkg::S_BOOT]))
    else $error("boot level not captured in reset");

  chk_flag_after: assert property (
    $fell(dev_rst) |-> external_flag_oe_o && external_flag_out_o)
    else $error("external flag not driven high after reset");

  chk_gpio_input: assert property (
    dev_rst |=> dir_q == rip_pkg::ZERO3)
    else $error("general-purpose pin not input after reset");

  chk_crystal_float: assert property (
    $fell(s3_q[rip_pkg::S_EMU]) && !s2_q[rip_pkg::S_EMU] |=> !crystal_out_oe_o)
    else $error("crystal output driven while disabled");

  chk_hiz_persist: assert property (
    (pwm_a_hiz_o && !dev_rst && !(wr && paddr_i == rip_pkg::A_STAT))
    |=> pwm_a_hiz_o || dev_rst)
    else $error("PWM float released without clear");

endmodule : rip_pin_ctrl

`default_nettype wire

/* File: sim/rip_board_model.sv */
// Purpose: Board side of the reset, interrupt and shared pins
// Assumes: Reset pin has a pull-up and is open drain; shared and boot pins follow board sources while the device does not drive them
// Notes:   Resolves device drive against board sources

`timescale 1ns/1ps
`default_nettype none

module rip_board_model (
  // Device drive
  input  wire logic       rst_o_i,
  input  wire logic       rst_oe_i,
  input  wire logic [2:0] mux_o_i,
  input  wire logic [2:0] mux_oe_i,
  input  wire logic       flag_i,
  input  wire logic       flag_oe_i,
  // Board sources
  input  wire logic [2:0] ext_mux_i,
  input  wire logic       boot_ext_i,
  // Resolved pin levels
  output logic            rst_pin_o,
  output logic      [2:0] mux_pin_o,
  output logic            boot_pin_o
);
  // Pull-up wins unless the watchdog pulse pulls the pin low
  assign rst_pin_o  = rst_oe_i ? rst_o_i : 1'b1;
  assign mux_pin_o  = (mux_oe_i & mux_o_i) | (~mux_oe_i & ext_mux_i);
  // Passive boot strap is overridden once the flag driver is on
  assign boot_pin_o = flag_oe_i ? flag_i : boot_ext_i;
endmodule : rip_board_model

`default_nettype wire

/* File: sim/rip_pin_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the pin control block
// Assumes: APB answers by pready; pins pass a short synchroniser
// Notes:   Pin waits of 6 cycles cover the sync and filter latency

`timescale 1ns/1ps
`default_nettype none

module rip_pin_ctrl_tb_top;
  logic        sys_clk, wd_clk, rst_o;
  logic        resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, rst_pin, rst_oe, halt, conv, irq;
  logic        wd_ov = 1'b0, fa = 1'b1, fb = 1'b1, boot_ext = 1'b0, emu_n = 1'b1;
  logic        hiz_a, hiz_b, boot_pin, flag, flag_oe, xo, xo_oe;
  logic [15:0] pc;
  logic [2:0]  mux_pin, mux_o, mux_oe, ext_mux = 3'h7;
  int          error_cnt = 0, checks = 0, conv_cnt = 0, n;
  logic [7:0]  ra [8] = '{rip_pkg::A_CTRL, rip_pkg::A_CTRL2, rip_pkg::A_STAT, rip_pkg::A_MASK,
                          rip_pkg::A_CFG, rip_pkg::A_FUNC, rip_pkg::A_DIR, rip_pkg::A_DOUT};
  logic [31:0] rv [8] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h7, 32'h0, 32'h0};

  rip_pin_ctrl u_rip_pin_ctrl (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .reset_in_n_i(rst_pin), .reset_in_n_o(rst_o),
    .reset_in_n_oe_o(rst_oe), .wd_overflow_i(wd_ov), .cpu_halt_o(halt),
    .program_counter_o(pc), .drive_fault_in_a_i(fa), .drive_fault_in_b_i(fb),
    .pwm_a_hiz_o(hiz_a), .pwm_b_hiz_o(hiz_b), .mux_pin_i(mux_pin), .mux_pin_o(mux_o),
    .mux_pin_oe_o(mux_oe), .watchdog_clock_i(wd_clk), .conv_start_in_o(conv),
    .boot_pin_i(boot_pin), .external_flag_out_o(flag), .external_flag_oe_o(flag_oe),
    .osc_drive_i(1'b1), .emu_output_disable_n_i(emu_n), .crystal_out_o(xo),
    .crystal_out_oe_o(xo_oe), .irq_o(irq));

  rip_board_model u_rip_board_model (
    .rst_o_i(rst_o), .rst_oe_i(rst_oe), .mux_o_i(mux_o), .mux_oe_i(mux_oe), .flag_i(flag),
    .flag_oe_i(flag_oe), .ext_mux_i(ext_mux), .boot_ext_i(boot_ext),
    .rst_pin_o(rst_pin), .mux_pin_o(mux_pin), .boot_pin_o(boot_pin));

  // ----------------------------------------------------------------
  // Clocks, helpers and bus tasks
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Watchdog clock phase is unrelated to the system clock on purpose
  initial begin
    wd_clk = 1'b0;
    forever #65 wd_clk = ~wd_clk;
  end
  always @(posedge sys_clk) if (conv === 1'b1) conv_cnt <= conv_cnt + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic stop_test;
    $display("Mismatches %0d comparisons %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    #(20000 * 50);
    error_cnt++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(10);
    chk(halt, 1'b1);
    chk(pc, 16'h0);
    chk(flag_oe, 1'b0);
    resetn <= 1'b1;
    for (int i = 0; i < 20 && halt !== 1'b0; i++) @(posedge sys_clk);
    chk(pc, 16'h0);
    cyc(1);
    chk(pc, 16'h1);
    chk({flag_oe, flag}, 2'h3);
    chk(mux_oe[1:0], 2'h0);
    for (int i = 0; i < 8; i++) rdchk(ra[i], rv[i]);
    apb(1'b0, 8'h40, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, rip_pkg::A_MASK, 32'hF);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      if (i == 0) fa <= 1'b0;
      else fb <= 1'b0;
      cyc(6);
      chk({irq, hiz_b, hiz_a}, 3'h5 + i);
      @(posedge sys_clk);
      fa <= 1'b1;
      fb <= 1'b1;
      cyc(6);
      chk({hiz_b, hiz_a}, 2'h1 << i);
      apb(1'b1, rip_pkg::A_STAT, 32'h1 << i);
      cyc(1);
      chk({irq, hiz_b, hiz_a}, 3'h0);
    end
    ext_mux[0] <= 1'b0;
    cyc(6);
    rdchk(rip_pkg::A_STAT, 32'h4);
    apb(1'b1, rip_pkg::A_STAT, 32'h4);
    cyc(4);
    rdchk(rip_pkg::A_STAT, 32'h0);
    ext_mux[0] <= 1'b1;
    cyc(6);
    rdchk(rip_pkg::A_STAT, 32'h0);
    apb(1'b1, rip_pkg::A_CFG, 32'h7);
    ext_mux[1] <= 1'b0;
    cyc(6);
    rdchk(rip_pkg::A_STAT, 32'h0);
    ext_mux[1] <= 1'b1;
    cyc(6);
    rdchk(rip_pkg::A_STAT, 32'h8);
    chk(conv_cnt, 1);
    apb(1'b1, rip_pkg::A_STAT, 32'h8);
    // Sample mid-phase so the clock pin has settled
    @(posedge sys_clk);
    #10 chk({mux_oe[2], mux_o[2]}, 2'h3);
    @(negedge sys_clk);
    #10 chk(mux_o[2], 1'b0);
    apb(1'b1, rip_pkg::A_CTRL, 32'h1 << rip_pkg::CLKSEL_BIT);
    repeat (4) begin
      @(posedge sys_clk);
      #10 chk(mux_o[2], wd_clk);
    end
    apb(1'b1, rip_pkg::A_FUNC, 32'h0);
    apb(1'b1, rip_pkg::A_DIR, 32'h7);
    apb(1'b1, rip_pkg::A_DOUT, 32'h5);
    cyc(1);
    chk({mux_oe, mux_o}, 6'h3D);
    emu_n <= 1'b0;
    cyc(6);
    chk({xo_oe, xo}, 2'h1);
    emu_n <= 1'b1;
    cyc(6);
    chk(xo_oe, 1'b1);
    boot_ext <= 1'b1;
    wd_ov    <= 1'b1;
    cyc(1);
    wd_ov    <= 1'b0;
    n = 0;
    repeat (30) begin
      @(posedge sys_clk);
      if (rst_pin === 1'b0 && halt === 1'b1) n++;
    end
    chk(n, rip_pkg::WD_PULSE_CYC);
    rdchk(rip_pkg::A_CTRL2, 32'h9);
    rdchk(rip_pkg::A_MASK, 32'h0);
    chk({mux_oe[1:0], boot_pin}, 3'h1);
    stop_test();
  end
endmodule : rip_pin_ctrl_tb_top

`default_nettype wire
